/* include/pcs_pkg.sv */
// Constants for the programmable pad cell with storage elements
package pcs_pkg;
  // Register byte offsets
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_INV      = 4'h4;
  localparam logic [3:0]  ADDR_ELEM     = 4'h8;
  localparam logic [3:0]  ADDR_STATUS   = 4'hC;
  // Control register fields
  localparam int          CTRL_OUT_STORE  = 0;
  localparam int          CTRL_HIZ_STORE  = 1;
  localparam int          CTRL_OUT_DUAL   = 2;
  localparam int          CTRL_HIZ_DUAL   = 3;
  localparam int          CTRL_TAP_LSB    = 4;
  localparam int          CTRL_TAP_W      = 3;
  localparam int          CTRL_IN_CE_CON  = 7;
  localparam int          CTRL_OUT_CE_CON = 8;
  localparam int          CTRL_HIZ_CE_CON = 9;
  localparam int          CTRL_W          = 10;
  // Inversion bit positions, one per pad, data, clock, enable and force input; global nets have none
  localparam int          INV_PAD     = 0;
  localparam int          INV_OD1     = 1;
  localparam int          INV_OD2     = 2;
  localparam int          INV_HZ1     = 3;
  localparam int          INV_HZ2     = 4;
  localparam int          INV_OHCLK_U = 5;
  localparam int          INV_OHCLK_L = 6;
  localparam int          INV_ICLK_U  = 7;
  localparam int          INV_ICLK_L  = 8;
  localparam int          INV_OUT_EN  = 9;
  localparam int          INV_HIZ_EN  = 10;
  localparam int          INV_IN_EN   = 11;
  localparam int          INV_FORCE   = 12;
  localparam int          INV_OPP     = 13;
  localparam int          INV_W       = 14;
  // Per-element option fields, element n at bit n*ELEM_FW
  localparam int          ELEM_FW       = 5;
  localparam int          ELEM_LATCH    = 0;
  localparam int          ELEM_ASYNC    = 1;
  localparam int          ELEM_POL      = 2;
  localparam int          ELEM_INIT_OWN = 3;
  localparam int          ELEM_INIT_VAL = 4;
  localparam int          NUM_ELEM      = 6;
  localparam int          ELEM_W        = NUM_ELEM * ELEM_FW;
  // Element order: input upper/lower, output upper/lower, hiz upper/lower
  localparam int          EL_IN_U  = 0;
  localparam int          EL_IN_L  = 1;
  localparam int          EL_OUT_U = 2;
  localparam int          EL_OUT_L = 3;
  localparam int          EL_HIZ_U = 4;
  localparam int          EL_HIZ_L = 5;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [INV_W-1:0]  INV_RST  = 14'h0000;
  localparam logic [ELEM_W-1:0] ELEM_RST = 30'h0000_0000;
  // Pad input delay line depth
  localparam int          DLY_DEPTH = 8;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

/* design/pcs_pad_cell.sv */
// Pad cell with input, output and hiz paths, six storage elements, AXI4-Lite setup
`timescale 1ns/1ps
module pcs_pad_cell
  import pcs_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [3:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        PAD_IN_I,
  output logic             PAD_OUT_O,
  output logic             PAD_OE_O,
  output logic             PAD_DIRECT_O,
  output logic             CAPTURED_FIRST_O,
  output logic             CAPTURED_SECOND_O,
  input  wire logic        OUT_DATA_FIRST_I,
  input  wire logic        OUT_DATA_SECOND_I,
  input  wire logic        HIZ_CTRL_FIRST_I,
  input  wire logic        HIZ_CTRL_SECOND_I,
  input  wire logic        OUT_HIZ_UPPER_CLK_I,
  input  wire logic        OUT_HIZ_LOWER_CLK_I,
  input  wire logic        IN_UPPER_CLK_I,
  input  wire logic        IN_LOWER_CLK_I,
  input  wire logic        OUT_PAIR_ENABLE_I,
  input  wire logic        HIZ_PAIR_ENABLE_I,
  input  wire logic        IN_PAIR_ENABLE_I,
  input  wire logic        SET_RESET_FORCE_I,
  input  wire logic        OPPOSITE_FORCE_I,
  input  wire logic        GLOBAL_SET_RESET_I,
  input  wire logic        GLOBAL_HIZ_NET_I
);

  typedef struct packed {
    logic [CTRL_W-1:0]    ctrl;
    logic [INV_W-1:0]     inv;
    logic [ELEM_W-1:0]    elem_cfg;
    logic [NUM_ELEM-1:0]  q;
    logic [3:0]           clk_prev;
    logic [2:0]           pad_sync;
    logic                 pad_clean;
    logic [DLY_DEPTH-1:0] dly;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 pad_out;
    logic                 pad_oe;
    logic                 pad_direct;
  } pcs_state_t;

  // Reset clears elements to zero; initial values need a global set/reset or global hiz net event
  localparam pcs_state_t STATE_RST = '{
    ctrl: CTRL_RST, inv: INV_RST, elem_cfg: ELEM_RST, q: '0, clk_prev: '0,
    pad_sync: '0, pad_clean: 1'b0, dly: '0, awready: 1'b0, wready: 1'b0,
    bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
    rresp: RESP_OKAY, rdata: '0, pad_out: 1'b0, pad_oe: 1'b0,
    pad_direct: 1'b0};

  pcs_state_t state_r;
  pcs_state_t state_nxt;

  // Strobed bytes replace, the rest keep the current register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    logic [INV_W-1:0]    sig;
    logic [3:0]          clk_lvl;
    logic [3:0]          clk_rise;
    logic [NUM_ELEM-1:0] d;
    logic [NUM_ELEM-1:0] e_lvl;
    logic [NUM_ELEM-1:0] e_rise;
    logic [NUM_ELEM-1:0] e_ce;
    logic [NUM_ELEM-1:0] latch;
    logic [NUM_ELEM-1:0] async_f;
    logic [NUM_ELEM-1:0] pol;
    logic [NUM_ELEM-1:0] init;
    logic                ce_in;
    logic                ce_out;
    logic                ce_hiz;
    logic                force_v;
    logic                force_on;
    logic                out_sel_u;
    logic                out_sel_l;
    logic                hiz_sel_u;
    logic                hiz_sel_l;
    logic                out_val;
    logic                hiz_val;
    logic [31:0]         wr_word;
    logic [31:0]         rd_word;
    logic [2:0]          tap;
    // Every local starts defined so no branch leaves a stale value
    sig       = '0;
    clk_lvl   = '0;
    clk_rise  = '0;
    d         = '0;
    e_lvl     = '0;
    e_rise    = '0;
    e_ce      = '0;
    latch     = '0;
    async_f   = '0;
    pol       = '0;
    init      = '0;
    ce_in     = 1'b0;
    ce_out    = 1'b0;
    ce_hiz    = 1'b0;
    force_v   = 1'b0;
    force_on  = 1'b0;
    out_sel_u = 1'b0;
    out_sel_l = 1'b0;
    hiz_sel_u = 1'b0;
    hiz_sel_l = 1'b0;
    out_val   = 1'b0;
    hiz_val   = 1'b0;
    wr_word   = 32'h0000_0000;
    rd_word   = 32'h0000_0000;
    tap       = 3'h0;

    state_nxt = state_r;

    // Pad is asynchronous: three stages, change accepted when stages two and three agree
    state_nxt.pad_sync = {state_r.pad_sync[1:0], PAD_IN_I};
    if (state_r.pad_sync[1] == state_r.pad_sync[2]) begin
      state_nxt.pad_clean = state_r.pad_sync[2];
    end

    sig = {OPPOSITE_FORCE_I, SET_RESET_FORCE_I, IN_PAIR_ENABLE_I, HIZ_PAIR_ENABLE_I,
           OUT_PAIR_ENABLE_I, IN_LOWER_CLK_I, IN_UPPER_CLK_I, OUT_HIZ_LOWER_CLK_I,
           OUT_HIZ_UPPER_CLK_I, HIZ_CTRL_SECOND_I, HIZ_CTRL_FIRST_I,
           OUT_DATA_SECOND_I, OUT_DATA_FIRST_I, state_r.pad_clean} ^ state_r.inv;

    // Programmable delay line on the pad input
    // Tap zero bypasses the line; each further tap adds one cycle
    state_nxt.dly = {state_r.dly[DLY_DEPTH-2:0], sig[INV_PAD]};
    tap = state_r.ctrl[CTRL_TAP_LSB +: CTRL_TAP_W];
    state_nxt.pad_direct = (tap == 3'h0) ? sig[INV_PAD] : state_r.dly[tap - 3'h1];

    // Clock lines are plain logic signals; edges found against last cycle
    // A clock line held high through reset shows one rise at release
    clk_lvl  = {sig[INV_ICLK_L], sig[INV_ICLK_U], sig[INV_OHCLK_L], sig[INV_OHCLK_U]};
    clk_rise = clk_lvl & ~state_r.clk_prev;
    state_nxt.clk_prev = clk_lvl;

    // Enable left unconnected reads as asserted
    ce_in  = sig[INV_IN_EN] | ~state_r.ctrl[CTRL_IN_CE_CON];
    ce_out = sig[INV_OUT_EN] | ~state_r.ctrl[CTRL_OUT_CE_CON];
    ce_hiz = sig[INV_HIZ_EN] | ~state_r.ctrl[CTRL_HIZ_CE_CON];

    // Clock fan-out to the six elements
    e_lvl  = {clk_lvl[1], clk_lvl[0], clk_lvl[1], clk_lvl[0], clk_lvl[3], clk_lvl[2]};
    e_rise = {clk_rise[1], clk_rise[0], clk_rise[1], clk_rise[0],
              clk_rise[3], clk_rise[2]};
    e_ce   = {ce_hiz, ce_hiz, ce_out, ce_out, ce_in, ce_in};
    // Both input elements see the delayed pad
    d      = {sig[INV_HZ2], sig[INV_HZ1], sig[INV_OD2], sig[INV_OD1],
              state_r.pad_direct, state_r.pad_direct};

    for (int n = 0; n < NUM_ELEM; n++) begin
      latch[n]   = state_r.elem_cfg[n*ELEM_FW + ELEM_LATCH];
      async_f[n] = state_r.elem_cfg[n*ELEM_FW + ELEM_ASYNC];
      pol[n]     = state_r.elem_cfg[n*ELEM_FW + ELEM_POL];
      // Initial value defaults to force polarity
      init[n]    = state_r.elem_cfg[n*ELEM_FW + ELEM_INIT_OWN] ?
                   state_r.elem_cfg[n*ELEM_FW + ELEM_INIT_VAL] : pol[n];
    end
    // Dual-edge pair takes the upper polarity
    if (state_r.ctrl[CTRL_OUT_DUAL]) begin
      pol[EL_OUT_L] = pol[EL_OUT_U];
    end
    if (state_r.ctrl[CTRL_HIZ_DUAL]) begin
      pol[EL_HIZ_L] = pol[EL_HIZ_U];
    end
    // A zero on either side of a dual-edge pair wins
    if (state_r.ctrl[CTRL_OUT_DUAL]) begin
      init[EL_OUT_U] = init[EL_OUT_U] & init[EL_OUT_L];
      init[EL_OUT_L] = init[EL_OUT_U];
    end
    if (state_r.ctrl[CTRL_HIZ_DUAL]) begin
      init[EL_HIZ_U] = init[EL_HIZ_U] & init[EL_HIZ_L];
      init[EL_HIZ_L] = init[EL_HIZ_U];
    end

    // Force lines shared by all elements
    // Asynchronous force still only takes effect at system clock edges
    force_on = sig[INV_FORCE] | sig[INV_OPP];
    for (int n = 0; n < NUM_ELEM; n++) begin
      // Opposite force inverts polarity; set/reset takes precedence
      force_v = sig[INV_FORCE] ? pol[n] : ~pol[n];
      // Global events load the initial value first
      if (GLOBAL_SET_RESET_I || GLOBAL_HIZ_NET_I) begin
        state_nxt.q[n] = init[n];
      // Force, clocked or not per element
      end else if (force_on && (async_f[n] || e_rise[n])) begin
        state_nxt.q[n] = force_v;
      // Latch mode transparent while gate high and enabled
      end else if (latch[n]) begin
        if (e_lvl[n] && e_ce[n]) begin
          state_nxt.q[n] = d[n];
        end
      // Flip-flop stores on enabled rising edge
      end else if (e_rise[n] && e_ce[n]) begin
        state_nxt.q[n] = d[n];
      end
    end

    // Element view: transparent latch follows data, else stored state
    // View bypasses the register so an open latch costs no extra cycle
    out_sel_u = (latch[EL_OUT_U] && e_lvl[EL_OUT_U] && e_ce[EL_OUT_U]) ?
                d[EL_OUT_U] : state_r.q[EL_OUT_U];
    out_sel_l = (latch[EL_OUT_L] && e_lvl[EL_OUT_L] && e_ce[EL_OUT_L]) ?
                d[EL_OUT_L] : state_r.q[EL_OUT_L];
    hiz_sel_u = (latch[EL_HIZ_U] && e_lvl[EL_HIZ_U] && e_ce[EL_HIZ_U]) ?
                d[EL_HIZ_U] : state_r.q[EL_HIZ_U];
    hiz_sel_l = (latch[EL_HIZ_L] && e_lvl[EL_HIZ_L] && e_ce[EL_HIZ_L]) ?
                d[EL_HIZ_L] : state_r.q[EL_HIZ_L];
    // Output mux: storage pair or direct lines
    if (!state_r.ctrl[CTRL_OUT_STORE]) begin
      out_sel_u = d[EL_OUT_U];
      out_sel_l = d[EL_OUT_L];
    end
    // Hiz mux: storage pair or direct lines
    if (!state_r.ctrl[CTRL_HIZ_STORE]) begin
      hiz_sel_u = d[EL_HIZ_U];
      hiz_sel_l = d[EL_HIZ_L];
    end
    // Dual-edge selection by the upper clock level
    // Upper value while upper clock high, lower otherwise
    out_val = (state_r.ctrl[CTRL_OUT_DUAL] && !clk_lvl[0]) ? out_sel_l : out_sel_u;
    hiz_val = (state_r.ctrl[CTRL_HIZ_DUAL] && !clk_lvl[0]) ? hiz_sel_l : hiz_sel_u;
    state_nxt.pad_out = out_val;
    // Global hiz net floats the driver regardless of the path
    state_nxt.pad_oe  = ~hiz_val & ~GLOBAL_HIZ_NET_I;

    // AXI4-Lite write: address and data taken together, response follows
    // No ready while a response waits, so one write is in flight at most
    state_nxt.awready = 1'b0;
    state_nxt.wready  = 1'b0;
    if (S_AXI_AWVALID_I && S_AXI_WVALID_I && !state_r.awready && !state_r.bvalid) begin
      state_nxt.awready = 1'b1;
      state_nxt.wready  = 1'b1;
    end
    if (state_r.bvalid && S_AXI_BREADY_I) begin
      state_nxt.bvalid = 1'b0;
    end
    if (state_r.awready && S_AXI_AWVALID_I && S_AXI_WVALID_I) begin
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp  = RESP_OKAY;
      case (S_AXI_AWADDR_I)
        ADDR_CTRL: begin
          wr_word = merge_bytes({22'h00_0000, state_r.ctrl}, S_AXI_WDATA_I, S_AXI_WSTRB_I);
          state_nxt.ctrl = wr_word[CTRL_W-1:0];
        end
        ADDR_INV: begin
          wr_word = merge_bytes({18'h0_0000, state_r.inv}, S_AXI_WDATA_I, S_AXI_WSTRB_I);
          state_nxt.inv = wr_word[INV_W-1:0];
        end
        ADDR_ELEM: begin
          wr_word = merge_bytes({2'b00, state_r.elem_cfg}, S_AXI_WDATA_I, S_AXI_WSTRB_I);
          state_nxt.elem_cfg = wr_word[ELEM_W-1:0];
        end
        ADDR_STATUS: begin
          // Read-only; write ignored
          state_nxt.bresp = RESP_OKAY;
        end
        default: begin
          state_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // AXI4-Lite read
    // Same single-outstanding scheme as the write side
    state_nxt.arready = 1'b0;
    if (S_AXI_ARVALID_I && !state_r.arready && !state_r.rvalid) begin
      state_nxt.arready = 1'b1;
    end
    if (state_r.rvalid && S_AXI_RREADY_I) begin
      state_nxt.rvalid = 1'b0;
    end
    if (state_r.arready && S_AXI_ARVALID_I) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = RESP_OKAY;
      case (S_AXI_ARADDR_I)
        ADDR_CTRL:   rd_word = {22'h00_0000, state_r.ctrl};
        ADDR_INV:    rd_word = {18'h0_0000, state_r.inv};
        ADDR_ELEM:   rd_word = {2'b00, state_r.elem_cfg};
        ADDR_STATUS: rd_word = {23'h00_0000, state_r.pad_oe, state_r.pad_out,
                                state_r.pad_clean, state_r.q};
        default: begin
          rd_word = 32'h0000_0000;
          state_nxt.rresp = RESP_SLVERR;
        end
      endcase
      state_nxt.rdata = rd_word;
    end
  end

  // Synchronous reset: state only changes at the system clock edge
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // All outputs come from state_r, so every port is a flip-flop
  assign S_AXI_AWREADY_O   = state_r.awready;
  assign S_AXI_WREADY_O    = state_r.wready;
  assign S_AXI_BRESP_O     = state_r.bresp;
  assign S_AXI_BVALID_O    = state_r.bvalid;
  assign S_AXI_ARREADY_O   = state_r.arready;
  assign S_AXI_RDATA_O     = state_r.rdata;
  assign S_AXI_RRESP_O     = state_r.rresp;
  assign S_AXI_RVALID_O    = state_r.rvalid;
  assign PAD_OUT_O         = state_r.pad_out;
  assign PAD_OE_O          = state_r.pad_oe;
  assign PAD_DIRECT_O      = state_r.pad_direct;
  assign CAPTURED_FIRST_O  = state_r.q[EL_IN_U];
  assign CAPTURED_SECOND_O = state_r.q[EL_IN_L];

endmodule

/* verification/pcs_pad_properties.sv */
// Port-level assertions for the pad cell
`timescale 1ns/1ps
module pcs_pad_props (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic        PAD_OUT_O,
  input wire logic        PAD_OE_O,
  input wire logic        GLOBAL_HIZ_NET_I
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  property p_aw_answer;
    S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_AWREADY_O && !S_AXI_BVALID_O
      |-> ##[1:3] S_AXI_AWREADY_O;
  endproperty
  a_aw_answer: assert property (p_aw_answer) else $error("write address not accepted in time");
  property p_aw_pulse;
    S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O && S_AXI_BVALID_O;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("write ready not a pulse before response");
  property p_w_with_aw;
    S_AXI_AWREADY_O == S_AXI_WREADY_O;
  endproperty
  a_w_with_aw: assert property (p_w_with_aw) else $error("write data ready apart from address");
  property p_b_cause;
    $rose(S_AXI_BVALID_O) |-> $past(S_AXI_AWREADY_O);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("write response without accepted write");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped or changed");
  property p_r_answer;
    S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data not following address");
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed");
  property p_ghz;
    GLOBAL_HIZ_NET_I && $past(GLOBAL_HIZ_NET_I) |-> !PAD_OE_O;
  endproperty
  a_ghz: assert property (p_ghz) else $error("pad driven during global hiz");
  property p_rst;
    $rose(RST_N_I) |-> !PAD_OE_O && !PAD_OUT_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_write: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
  c_ghz: cover property (GLOBAL_HIZ_NET_I && $past(GLOBAL_HIZ_NET_I));
endmodule
bind pcs_pad_cell pcs_pad_props u_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .PAD_OUT_O(PAD_OUT_O), .PAD_OE_O(PAD_OE_O), .GLOBAL_HIZ_NET_I(GLOBAL_HIZ_NET_I)
);

/* verification/pcs_pad_model.sv */
// Far-side pad model: resolves the pad wire from the cell and an outside driver
`timescale 1ns/1ps
module pcs_pad_model (
  input  wire logic clk_i,
  input  wire logic oe_i,
  input  wire logic dout_i,
  input  wire logic ext_en_i,
  input  wire logic ext_val_i,
  output logic      pad_o
);
  logic last_r = 1'b0;
  // A floating pad toggles so a stale value can never pass for a driven one
  always_comb begin
    if (oe_i)
      pad_o = dout_i;
    else if (ext_en_i)
      pad_o = ext_val_i;
    else
      pad_o = ~last_r;
  end
  always_ff @(posedge clk_i) begin
    last_r <= pad_o;
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the pad cell
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  localparam int OD1 = 0, OD2 = 1, HZ1 = 2, OHU = 3, OHL = 4, IU = 5, IL = 6, OEN = 7;
  localparam int FRC = 8, OPP = 9, GSR = 10, GHZ = 11, HZ2 = 12, HEN = 13, IEN = 14;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ext_en, ext_val;
  logic        pad_in, pad_out, pad_oe, pad_dir, cap1, cap2;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0]  bresp, rresp;
  logic [14:0] lg;
  int          n_errors, num_checks, cycles;
  pcs_pad_cell dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out), .PAD_OE_O(pad_oe), .PAD_DIRECT_O(pad_dir),
    .CAPTURED_FIRST_O(cap1), .CAPTURED_SECOND_O(cap2), .OUT_DATA_FIRST_I(lg[OD1]),
    .OUT_DATA_SECOND_I(lg[OD2]), .HIZ_CTRL_FIRST_I(lg[HZ1]), .HIZ_CTRL_SECOND_I(lg[HZ2]),
    .OUT_HIZ_UPPER_CLK_I(lg[OHU]), .OUT_HIZ_LOWER_CLK_I(lg[OHL]), .IN_UPPER_CLK_I(lg[IU]),
    .IN_LOWER_CLK_I(lg[IL]), .OUT_PAIR_ENABLE_I(lg[OEN]), .HIZ_PAIR_ENABLE_I(lg[HEN]),
    .IN_PAIR_ENABLE_I(lg[IEN]), .SET_RESET_FORCE_I(lg[FRC]), .OPPOSITE_FORCE_I(lg[OPP]),
    .GLOBAL_SET_RESET_I(lg[GSR]), .GLOBAL_HIZ_NET_I(lg[GHZ])
  );
  pcs_pad_model pad (.clk_i(clk), .oe_i(pad_oe), .dout_i(pad_out), .ext_en_i(ext_en),
                     .ext_val_i(ext_val), .pad_o(pad_in));
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(int k, logic v);
    @(posedge clk);
    lg[k] <= v;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic rd(logic [3:0] a, logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  function automatic logic [31:0] ef(int e, logic [4:0] f);
    return 32'(f) << (e * ELEM_FW);
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run should take a few hundred cycles; anything far beyond is a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ext_val} = '0;
    {awaddr, araddr, wdata, lg} = '0;
    wstrb = 4'hF;
    ext_en = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, RESP_OKAY);
    chk("ctrl", rdv, 32'(CTRL_RST));
    rd(ADDR_INV, RESP_OKAY);
    chk("inv", rdv, 32'(INV_RST));
    rd(ADDR_ELEM, RESP_OKAY);
    chk("elem", rdv, 32'(ELEM_RST));
    wr(ADDR_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY);
    chk("ctrl", rdv, 32'h0000_03FF);
    wstrb <= 4'h2;
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_CTRL, RESP_OKAY);
    chk("ctrl_strobe", rdv, 32'h0000_00FF);
    wr(4'h2, 32'h0000_0001, RESP_SLVERR);
    rd(4'h2, RESP_SLVERR);
    chk("unmapped", rdv, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_INV, 32'((i >> 1) << INV_OD1 | (i >> 1) << INV_HZ1), RESP_OKAY);
      put(OD1, i[0]);
      cyc(3);
      chk("pad_out", 32'(pad_out), 32'(i[0] ^ i[1]));
      chk("pad_oe", 32'(pad_oe), 32'(!i[1]));
    end
    wr(ADDR_INV, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0101, RESP_OKAY);
    put(OHU, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0000);
    put(OHU, 1'b0);
    put(OEN, 1'b1);
    put(OHU, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    put(OD1, 1'b0);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    wr(ADDR_ELEM, ef(EL_OUT_U, 5'b00001), RESP_OKAY);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0000);
    put(OD1, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    put(OHU, 1'b0);
    put(OD1, 1'b0);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    wr(ADDR_ELEM, ef(EL_OUT_U, 5'b00010), RESP_OKAY);
    put(FRC, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0000);
    put(FRC, 1'b0);
    put(OPP, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    put(OPP, 1'b0);
    wr(ADDR_ELEM, 32'h0000_0000, RESP_OKAY);
    put(OD1, 1'b1);
    put(FRC, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0001);
    put(OHU, 1'b1);
    cyc(3);
    chk("pad_out", 32'(pad_out), 32'h0000_0000);
    put(FRC, 1'b0);
    put(OHU, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0105, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_ELEM, ef(EL_OUT_U, 5'b00100) | ef(EL_OUT_L, i ? 5'b01000 : 5'b11000), RESP_OKAY);
      put(GSR, 1'b1);
      put(GSR, 1'b0);
      rd(ADDR_STATUS, RESP_OKAY);
      chk("status", rdv & 32'h0000_003F, i ? 32'h0000_0000 : 32'h0000_000C);
    end
    wr(ADDR_ELEM, ef(EL_OUT_U, 5'b00110) | ef(EL_OUT_L, 5'b00010), RESP_OKAY);
    put(FRC, 1'b1);
    rd(ADDR_STATUS, RESP_OKAY);
    chk("status", rdv & 32'h0000_003F, 32'h0000_000C);
    put(FRC, 1'b0);
    wr(ADDR_ELEM, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      put(OD1, !i[0]);
      put(OD2, i[0]);
      put(OHU, 1'b1);
      put(OHL, 1'b0);
      cyc(3);
      chk("pad_out", 32'(pad_out), 32'(!i[0]));
      put(OHU, 1'b0);
      put(OHL, 1'b1);
      cyc(3);
      chk("pad_out", 32'(pad_out), 32'(i[0]));
    end
    put(GHZ, 1'b1);
    cyc(3);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0000);
    put(GHZ, 1'b0);
    cyc(3);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0070, RESP_OKAY);
    put(HZ1, 1'b1);
    cyc(20);
    chk("pad_direct", 32'(pad_dir), 32'h0000_0000);
    ext_val <= 1'b1;
    cyc(8);
    chk("pad_direct", 32'(pad_dir), 32'h0000_0000);
    cyc(8);
    chk("pad_direct", 32'(pad_dir), 32'h0000_0001);
    put(IU, 1'b1);
    cyc(3);
    chk("captured_first", 32'(cap1), 32'h0000_0001);
    chk("captured_second", 32'(cap2), 32'h0000_0000);
    put(IL, 1'b1);
    cyc(3);
    chk("captured_second", 32'(cap2), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0202, RESP_OKAY);
    cyc(3);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0001);
    put(OHU, 1'b1);
    cyc(3);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0001);
    put(OHU, 1'b0);
    put(HEN, 1'b1);
    put(OHU, 1'b1);
    cyc(3);
    chk("pad_oe", 32'(pad_oe), 32'h0000_0000);
    test_done();
  end
endmodule
